// ---- dfsch_pkg.sv ----
`default_nettype none
package dfsch_pkg;
	// ------------------------------------------------------------
	// Packet codes
	// ------------------------------------------------------------
	localparam logic [7:0] RSP_FLAG   = 8'h40; // Normal answer
	localparam logic [7:0] ERR_FLAG   = 8'hC0; // Refused command
	localparam logic [7:0] CMD_STORE  = 8'h04;
	localparam logic [7:0] CMD_CLEAR  = 8'h06;
	localparam logic [7:0] CMD_LINE1  = 8'h07;
	localparam logic [7:0] CMD_LINE2  = 8'h08;
	localparam logic [7:0] CMD_GLYPH  = 8'h09;
	localparam logic [7:0] CMD_MEMRD  = 8'h0A;
	localparam logic [7:0] CMD_CURPOS = 8'h0B;
	localparam logic [7:0] CMD_CURSTY = 8'h0C;
	localparam logic [7:0] CMD_FANRPT = 8'h10;
	localparam logic [7:0] CMD_FANPWR = 8'h11;
	localparam logic [7:0] CMD_OWINFO = 8'h12;
	localparam logic [7:0] RPT_FAN    = 8'h81;
	// ------------------------------------------------------------
	// Payload lengths and limits
	// ------------------------------------------------------------
	localparam logic [7:0] LEN_NONE    = 8'h00;
	localparam logic [7:0] LEN_ONE     = 8'h01;
	localparam logic [7:0] LEN_CURPOS  = 8'h02;
	localparam logic [7:0] LEN_FANPWR  = 8'h04;
	localparam logic [7:0] LEN_GLYPH   = 8'h09;
	localparam logic [7:0] LEN_LINE    = 8'h10;
	localparam logic [7:0] LEN_RD_RSP  = 8'h09;
	localparam logic [7:0] LEN_FAN_RSP = 8'h03;
	localparam logic [7:0] LEN_BAD     = 8'hFF; // Frame with no length byte
	localparam logic [7:0] GLYPH_MAX   = 8'h3F;
	localparam logic [7:0] FAN_FULL    = 8'h64; // 100 percent
	localparam logic [7:0] SPACE_CODE  = 8'h20;
	// ------------------------------------------------------------
	// Display memory layout
	// ------------------------------------------------------------
	localparam logic [5:0] ROW_CHARS = 6'h14; // 20 cells per row
	localparam int         LINE_OFS  = 2;     // Centre 16 of 20
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ      = 100;
	localparam int FAN_SLOT_MS  = 125; // One eighth of a second
	localparam int FAN_SLOT_CYC = FAN_SLOT_MS * 1000 * CLK_MHZ;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0]  REG_CTRL = 4'h0;
	localparam logic [3:0]  REG_STAT = 4'h4;
	localparam logic [3:0]  REG_FAN  = 4'h8;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_ERR = 2'h2;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	typedef enum logic [2:0] {ST_IDLE, ST_TYPE, ST_LEN, ST_PAY, ST_EXEC, ST_RSP} dfsch_state_e;
endpackage
`default_nettype wire

// ---- dfsch_top.sv ----
// Summary of operation
// - Answer type is command with bit 6
// - Clear fills spaces, cursor home
// - Write commands acknowledged with empty payload
// - Upper line gets 16 centre characters
// - Lower line gets 16 centre characters
// - Glyph command: index 0-7, rows to 63
// - Row bit 5 leftmost, first row top
// - Memory read takes one address byte
// - Memory read answers address plus eight bytes
// - Cursor command sets column and row
// - Cursor style picks one of four
// - Nonzero mask sends fan reports every 500ms
// - Fan reports spaced one eighth second
// - Reported fan forced full during its slot
// - Fan power takes four levels 0-100
// - One-wire table of 32 identities kept
// - One-wire info answers index plus identity
// - Only sensor family codes become eligible
// - Store command snapshots state for boot
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`default_nettype none
module dfsch_top #(
	parameter int         FAN_SLOT_CYC = dfsch_pkg::FAN_SLOT_CYC,
	parameter logic [7:0] TEMP_FAM_A   = 8'hA1, // Arbitrary value
	parameter logic [7:0] TEMP_FAM_B   = 8'hB2  // Arbitrary value
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        cmd_valid,
	output var  logic        cmd_ready,
	input  wire logic [7:0]  cmd_byte,
	input  wire logic        cmd_last,
	output var  logic        rsp_valid,
	input  wire logic        rsp_ready,
	output var  logic [7:0]  rsp_byte,
	output var  logic        rsp_last,
	input  wire logic [63:0] fan_tach,
	output var  logic [31:0] fan_level,
	output var  logic [3:0]  cursor_col,
	output var  logic        cursor_row,
	output var  logic [1:0]  cursor_style,
	input  wire logic        ow_wr_en,
	input  wire logic [7:0]  ow_wr_addr,
	input  wire logic [7:0]  ow_wr_data,
	output var  logic [31:0] temp_eligible,
	input  wire logic [7:0]  disp_rd_addr,
	output var  logic [7:0]  disp_rd_data,
	output var  logic        boot_save,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import dfsch_pkg::*;

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	dfsch_state_e st_q;
	logic [7:0]   typ_q;
	logic [7:0]   len_q;
	logic [4:0]   cnt_q;
	logic [4:0]   idx_q;
	logic [7:0]   rsp_len_q;
	logic         rpt_mode_q;
	logic [7:0]   pay_q [0:15];
	logic [7:0]   txt_q [0:39];
	logic [5:0]   glyph_q [0:63];
	logic [7:0]   ow_tab [0:255];
	logic [7:0]   pwr_q [0:3];
	logic [3:0]   mask_q;
	logic [23:0]  tick_cnt_q;
	logic [1:0]   slot_q;
	logic         rpt_pend_q;
	logic [1:0]   rpt_fan_q;
	logic         ctrl_en_q;
	logic         aw_held_q;
	logic         w_held_q;
	logic [3:0]   awaddr_q;
	logic [31:0]  wdata_q;
	logic         wstrb0_q;

	// Byte of glyph or text memory at a controller address
	function automatic logic [7:0] mem_at(input logic [7:0] a);
		logic [5:0] ti;
		ti = a[6] ? ROW_CHARS + a[5:0] : a[5:0];
		if (a[7:6] == 2'b01) begin
			mem_at = {2'b00, glyph_q[a[5:0]]};
		end else if (a[7] && a[5:0] < ROW_CHARS) begin
			mem_at = txt_q[ti];
		end else begin
			mem_at = 8'h00;
		end
	endfunction

	// ------------------------------------------------------------
	// Command checking
	// ------------------------------------------------------------
	logic glyph_ok;
	logic fan_ok;
	logic ctl_ok;
	// Range scans over the buffered payload
	always_comb begin
		glyph_ok = pay_q[0] < 8'h08;
		fan_ok = 1'b1;
		for (int i = 0; i < 8; i++) begin
			if (pay_q[i + 1] > GLYPH_MAX) glyph_ok = 1'b0;
		end
		for (int i = 0; i < 4; i++) begin
			if (pay_q[i] > FAN_FULL) fan_ok = 1'b0;
		end
	end

	wire       len_ok  = cnt_q == len_q[4:0] && len_q[7:5] == 3'b000;
	wire [7:0] a0      = pay_q[0];
	wire       addr_ok = a0[7:6] == 2'b01 || (a0[7] && a0[5:0] < ROW_CHARS);
	// Per-command length and value checks; anything else is refused
	always_comb begin
		case (typ_q)
			CMD_STORE:  ctl_ok = len_q == LEN_NONE;
			CMD_CLEAR:  ctl_ok = len_q == LEN_NONE;
			CMD_LINE1:  ctl_ok = len_q == LEN_LINE;
			CMD_LINE2:  ctl_ok = len_q == LEN_LINE;
			CMD_GLYPH:  ctl_ok = len_q == LEN_GLYPH && glyph_ok;
			CMD_MEMRD:  ctl_ok = len_q == LEN_ONE && addr_ok;
			CMD_CURPOS: ctl_ok = len_q == LEN_CURPOS && a0 < 8'h10 && pay_q[1] < 8'h02;
			CMD_CURSTY: ctl_ok = len_q == LEN_ONE && a0 < 8'h04;
			CMD_FANRPT: ctl_ok = len_q == LEN_ONE && a0[7:4] == 4'h0;
			CMD_FANPWR: ctl_ok = len_q == LEN_FANPWR && fan_ok;
			CMD_OWINFO: ctl_ok = len_q == LEN_ONE && a0 < 8'h20;
			default:    ctl_ok = 1'b0;
		endcase
	end

	wire cmd_ok  = len_ok && ctl_ok;
	wire exec_ok = st_q == ST_EXEC && cmd_ok;
	wire rd_cmd  = typ_q == CMD_MEMRD || typ_q == CMD_OWINFO;

	// ------------------------------------------------------------
	// Answer byte selection
	// ------------------------------------------------------------
	wire [7:0]  k      = {3'b000, idx_q} - 8'h02;
	wire [7:0]  k_m1   = k - 8'h01;
	wire [15:0] tach   = fan_tach[{rpt_fan_q, 4'h0} +: 16];
	wire [7:0]  rpt_b  = k == 8'h00 ? {6'b0, rpt_fan_q} : (k == 8'h01 ? tach[15:8] : tach[7:0]);
	wire [7:0]  mem_b  = mem_at(a0 + k_m1);
	wire [7:0]  ow_b   = ow_tab[{a0[4:0], k_m1[2:0]}];
	wire [7:0]  rd_b   = k == 8'h00 ? a0 : (typ_q == CMD_MEMRD ? mem_b : ow_b);
	wire [7:0]  nxt_b  = idx_q == 5'h01 ? rsp_len_q : (rpt_mode_q ? rpt_b : rd_b);
	wire        nxt_l  = {3'b000, idx_q} == rsp_len_q + 8'h01;
	wire        rsp_hs = rsp_valid && rsp_ready;
	wire        cmd_hs = cmd_valid && cmd_ready;
	wire        rpt_go = st_q == ST_IDLE && rpt_pend_q;

	// ------------------------------------------------------------
	// Packet sequencer
	// ------------------------------------------------------------
	// Reports win the idle slot so a silent host cannot starve them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q       <= ST_IDLE;
			cmd_ready  <= 1'b0;
			rsp_valid  <= 1'b0;
			rsp_last   <= 1'b0;
			rsp_byte   <= 8'h00;
			idx_q      <= 5'h00;
			cnt_q      <= 5'h00;
			typ_q      <= 8'h00;
			len_q      <= 8'h00;
			rsp_len_q  <= 8'h00;
			rpt_mode_q <= 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (rpt_pend_q) begin
						st_q       <= ST_RSP;
						rsp_valid  <= 1'b1;
						rsp_byte   <= RPT_FAN;
						rsp_last   <= 1'b0;
						rsp_len_q  <= LEN_FAN_RSP;
						rpt_mode_q <= 1'b1;
						idx_q      <= 5'h01;
					end else if (ctrl_en_q) begin
						st_q      <= ST_TYPE;
						cmd_ready <= 1'b1;
						cnt_q     <= 5'h00;
					end
				end
				ST_TYPE: begin
					if (cmd_hs) begin
						typ_q <= cmd_byte;
						len_q <= LEN_BAD;
						st_q  <= cmd_last ? ST_EXEC : ST_LEN;
						if (cmd_last) cmd_ready <= 1'b0;
					end else if (rpt_pend_q || !ctrl_en_q) begin
						cmd_ready <= 1'b0;
						st_q      <= ST_IDLE;
					end
				end
				ST_LEN: begin
					if (cmd_hs) begin
						len_q <= cmd_byte;
						st_q  <= cmd_last ? ST_EXEC : ST_PAY;
						if (cmd_last) cmd_ready <= 1'b0;
					end
				end
				ST_PAY: begin
					if (cmd_hs) begin
						if (cnt_q < 5'h10) pay_q[cnt_q[3:0]] <= cmd_byte;
						if (cnt_q != 5'h1F) cnt_q <= cnt_q + 5'h01;
						if (cmd_last) begin
							cmd_ready <= 1'b0;
							st_q      <= ST_EXEC;
						end
					end
				end
				ST_EXEC: begin
					st_q       <= ST_RSP;
					rsp_valid  <= 1'b1;
					rsp_last   <= 1'b0;
					rpt_mode_q <= 1'b0;
					idx_q      <= 5'h01;
					rsp_byte   <= typ_q | (cmd_ok ? RSP_FLAG : ERR_FLAG);
					rsp_len_q  <= (cmd_ok && rd_cmd) ? LEN_RD_RSP : LEN_NONE;
				end
				ST_RSP: begin
					if (rsp_hs) begin
						if (rsp_last) begin
							rsp_valid <= 1'b0;
							rsp_last  <= 1'b0;
							st_q      <= ST_IDLE;
						end else begin
							rsp_byte <= nxt_b;
							rsp_last <= nxt_l;
							idx_q    <= idx_q + 5'h01;
						end
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Display, cursor and fan settings
	// ------------------------------------------------------------
	// Refused commands never reach these writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 40; i++) txt_q[i] <= SPACE_CODE;
			for (int i = 0; i < 4; i++) pwr_q[i] <= FAN_FULL;
			cursor_col   <= 4'h0;
			cursor_row   <= 1'b0;
			cursor_style <= 2'h0;
			mask_q       <= 4'h0;
			boot_save    <= 1'b0;
		end else begin
			boot_save <= exec_ok && typ_q == CMD_STORE;
			if (exec_ok) begin
				case (typ_q)
					CMD_CLEAR: begin
						for (int i = 0; i < 40; i++) txt_q[i] <= SPACE_CODE;
						cursor_col <= 4'h0;
						cursor_row <= 1'b0;
					end
					CMD_LINE1: begin
						for (int i = 0; i < 16; i++) txt_q[LINE_OFS + i] <= pay_q[i];
					end
					CMD_LINE2: begin
						for (int i = 0; i < 16; i++) txt_q[20 + LINE_OFS + i] <= pay_q[i];
					end
					CMD_CURPOS: begin
						cursor_col <= a0[3:0];
						cursor_row <= pay_q[1][0];
					end
					CMD_CURSTY: cursor_style <= a0[1:0];
					CMD_FANRPT: mask_q <= a0[3:0];
					CMD_FANPWR: begin
						for (int i = 0; i < 4; i++) pwr_q[i] <= pay_q[i];
					end
					default: ;
				endcase
			end
		end
	end

	// Glyph rows kept as sent: bit 5 left, first row top
	always_ff @(posedge aclk) begin
		if (exec_ok && typ_q == CMD_GLYPH) begin
			for (int r = 0; r < 8; r++) glyph_q[{a0[2:0], r[2:0]}] <= pay_q[r + 1][5:0];
		end
	end

	// ------------------------------------------------------------
	// One-wire table, filled by the power-up enumerator
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (ow_wr_en) ow_tab[ow_wr_addr] <= ow_wr_data;
	end

	// Family code is byte 0 of each eight-byte identity
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			temp_eligible <= 32'h0000_0000;
		end else if (ow_wr_en && ow_wr_addr[2:0] == 3'h0) begin
			temp_eligible[ow_wr_addr[7:3]] <= ow_wr_data == TEMP_FAM_A || ow_wr_data == TEMP_FAM_B;
		end
	end

	// Refresh port for the panel driver
	always_ff @(posedge aclk) begin
		if (!aresetn) disp_rd_data <= 8'h00;
		else disp_rd_data <= mem_at(disp_rd_addr);
	end

	// ------------------------------------------------------------
	// Fan report slots
	// ------------------------------------------------------------
	wire       tick    = tick_cnt_q == 24'(FAN_SLOT_CYC - 1);
	wire [1:0] slot_nx = slot_q + 2'h1;
	// Four slots of 1/8 s make the half-second report period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_q <= 24'h00_0000;
			slot_q     <= 2'h0;
			rpt_pend_q <= 1'b0;
			rpt_fan_q  <= 2'h0;
		end else begin
			tick_cnt_q <= tick ? 24'h00_0000 : tick_cnt_q + 24'h00_0001;
			if (tick) slot_q <= slot_nx;
			if (tick && mask_q[slot_nx]) begin
				rpt_pend_q <= 1'b1;
				rpt_fan_q  <= slot_nx;
			end else if (rpt_go) begin
				rpt_pend_q <= 1'b0;
			end
		end
	end

	// Boost the reported fan whose slot is running; tach needs it spinning
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fan_level <= {4{FAN_FULL}};
		end else begin
			for (int i = 0; i < 4; i++) begin
				fan_level[8*i +: 8] <= (mask_q[i] && slot_q == i[1:0]) ? FAN_FULL : pwr_q[i];
			end
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	wire        wr_go   = aw_held_q && w_held_q && !s_axi_bvalid;
	wire        wr_bad  = awaddr_q != REG_CTRL && awaddr_q != REG_STAT && awaddr_q != REG_FAN;
	wire        busy    = st_q != ST_IDLE && st_q != ST_TYPE;
	wire [31:0] stat_w  = {19'h0, mask_q, cursor_style, cursor_row, cursor_col, rpt_pend_q, busy};
	wire [31:0] rd_word = s_axi_araddr == REG_CTRL ? {31'h0, ctrl_en_q} :
	                      s_axi_araddr == REG_STAT ? stat_w :
	                      s_axi_araddr == REG_FAN  ? fan_level : 32'h0000_0000;
	wire        rd_bad  = s_axi_araddr != REG_CTRL && s_axi_araddr != REG_STAT &&
	                      s_axi_araddr != REG_FAN;
	// Address and data taken in either order, answered once both held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			awaddr_q      <= 4'h0;
			wdata_q       <= 32'h0000_0000;
			wstrb0_q      <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OK;
			ctrl_en_q     <= CTRL_RST[0];
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q     <= 1'b1;
				awaddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q     <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb0_q     <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_bad ? RESP_ERR : RESP_OK;
				if (awaddr_q == REG_CTRL && wstrb0_q) ctrl_en_q <= wdata_q[0];
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_held_q     <= 1'b0;
				w_held_q      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// One read at a time, data captured at the address edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_bad ? RESP_ERR : RESP_OK;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_answer_type: assert property (exec_ok |=> rsp_byte == ($past(typ_q) | RSP_FLAG))
		else $error("answer type lacks response flag");
	chk_clear_fill: assert property (exec_ok && typ_q == CMD_CLEAR |=>
		txt_q[0] == SPACE_CODE && txt_q[39] == SPACE_CODE && cursor_col == 4'h0 && !cursor_row)
		else $error("clear left text or cursor");
	chk_ack_empty: assert property (exec_ok && typ_q == CMD_FANPWR |=> rsp_len_q == LEN_NONE)
		else $error("acknowledge carries payload");
	chk_line_upper: assert property (exec_ok && typ_q == CMD_LINE1 |=>
		txt_q[LINE_OFS] == $past(pay_q[0]) && txt_q[17] == $past(pay_q[15]))
		else $error("upper line misplaced");
	chk_line_lower: assert property (exec_ok && typ_q == CMD_LINE2 |=>
		txt_q[22] == $past(pay_q[0]) && txt_q[37] == $past(pay_q[15]))
		else $error("lower line misplaced");
	chk_glyph_range: assert property (st_q == ST_EXEC && typ_q == CMD_GLYPH && a0 > 8'h07
		|-> !cmd_ok)
		else $error("glyph index out of range accepted");
	chk_read_length: assert property (st_q == ST_RSP && idx_q == 5'h02 && !rpt_mode_q
		&& typ_q == CMD_MEMRD && cmd_ok |-> rsp_byte == LEN_RD_RSP)
		else $error("memory read length wrong");
	chk_cursor_move: assert property (exec_ok && typ_q == CMD_CURPOS |=>
		cursor_col == $past(a0[3:0]) && cursor_row == $past(pay_q[1][0]))
		else $error("cursor not moved");
	chk_fan_boost: assert property (mask_q[0] && slot_q == 2'h0 && $stable(mask_q) |=>
		fan_level[7:0] == FAN_FULL)
		else $error("reported fan not boosted");
	chk_pwr_refuse: assert property (st_q == ST_EXEC && typ_q == CMD_FANPWR && !fan_ok
		|=> rsp_byte == (CMD_FANPWR | ERR_FLAG))
		else $error("bad fan level accepted");
	chk_report_due: assert property (tick && mask_q[slot_nx] |=> rpt_pend_q)
		else $error("fan report not raised");

	cov_report: cover property (rpt_go);
	cov_mem_read: cover property (exec_ok && typ_q == CMD_MEMRD);
	cov_refused: cover property (st_q == ST_EXEC && !cmd_ok);
endmodule
`default_nettype wire

// ---- dfsch_host.sv ----
`default_nettype none
module dfsch_host (
	input  wire logic       aclk,
	output var  logic       cmd_valid,
	input  wire logic       cmd_ready,
	output var  logic [7:0] cmd_byte,
	output var  logic       cmd_last,
	input  wire logic       rsp_valid,
	output var  logic       rsp_ready,
	input  wire logic [7:0] rsp_byte,
	input  wire logic       rsp_last
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Host side of the packet link
	// ------------------------------------------------------------
	logic       slow = 1'b0;
	int         cyc  = 0;
	logic [7:0] rx_q[$];
	int         t_q[$];
	initial begin
		cmd_valid = 1'b0;
		cmd_byte  = 8'h00;
		cmd_last  = 1'b0;
		rsp_ready = 1'b0;
	end
	// Sink; slow mode stalls every other cycle to stretch answers
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (rsp_valid && rsp_ready) begin
			rx_q.push_back(rsp_byte);
			if (rsp_last)
				t_q.push_back(cyc);
		end
		rsp_ready <= slow ? !rsp_ready : 1'b1;
	end
	// Whole frame, each byte held until taken; idle bus shows the inverse
	task automatic send(input logic [7:0] f[$], output logic ok);
		int n;
		ok = 1'b1;
		foreach (f[i]) begin
			cmd_valid <= 1'b1;
			cmd_byte  <= f[i];
			cmd_last  <= (i == f.size() - 1);
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while (cmd_ready !== 1'b1 && n < 500);
			if (n >= 500)
				ok = 1'b0;
		end
		cmd_valid <= 1'b0;
		cmd_last  <= 1'b0;
		cmd_byte  <= ~f[f.size() - 1];
	endtask
endmodule
`default_nettype wire

// ---- dfsch_top_tb.sv ----
`default_nettype none
module dfsch_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dfsch_pkg::*;
	// ------------------------------------------------------------
	// Bench signals
	// ------------------------------------------------------------
	localparam int         SLOT  = 40;
	localparam logic [7:0] FAM_A = 8'hA1; // Arbitrary value
	logic        aclk = 1'b0, aresetn = 1'b0, ow_wr_en = 1'b0;
	logic        cmd_valid, cmd_ready, cmd_last, rsp_valid, rsp_ready, rsp_last, boot_save;
	logic [7:0]  cmd_byte, rsp_byte, disp_rd_data, ow_wr_addr = 8'h00, ow_wr_data = 8'h00;
	logic [7:0]  disp_rd_addr = 8'h80;
	logic        cursor_row, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [3:0]  cursor_col, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [1:0]  cursor_style, s_axi_bresp, s_axi_rresp;
	logic [31:0] fan_level, temp_eligible, s_axi_rdata, s_axi_wdata = 32'h0;
	logic [63:0] fan_tach = 64'h0004_0A03_0002_1BCD;
	int          num_errors = 0, comparisons = 0, saves = 0;
	dfsch_top #(.FAN_SLOT_CYC(SLOT), .TEMP_FAM_A(FAM_A)) u_dfsch_top (
		.aclk, .aresetn, .cmd_valid, .cmd_ready, .cmd_byte, .cmd_last, .rsp_valid, .rsp_ready,
		.rsp_byte, .rsp_last, .fan_tach, .fan_level, .cursor_col, .cursor_row, .cursor_style,
		.ow_wr_en, .ow_wr_addr, .ow_wr_data, .temp_eligible, .disp_rd_addr, .disp_rd_data,
		.boot_save, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);
	dfsch_host u_dfsch_host (
		.aclk, .cmd_valid, .cmd_ready, .cmd_byte, .cmd_last, .rsp_valid, .rsp_ready,
		.rsp_byte, .rsp_last
	);
	// Clock and store pulse counter
	always #5 aclk = ~aclk;
	always @(posedge aclk)
		if (boot_save === 1'b1)
			saves <= saves + 1;
	task automatic end_sim();
		if (num_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n >= 300) begin
			num_errors++;
			end_sim();
		end
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	// Next answer frame; fan reports skipped unless asked for
	task automatic get(output logic [7:0] b[$], output int t, input logic rpt);
		int n;
		n = 0;
		do begin
			while (u_dfsch_host.t_q.size() == 0 && n < 300) begin
				@(posedge aclk);
				n++;
			end
			tmo(n);
			t = u_dfsch_host.t_q.pop_front();
			b = {};
			repeat (int'(u_dfsch_host.rx_q[1]) + 2)
				b.push_back(u_dfsch_host.rx_q.pop_front());
		end while (b[0] === RPT_FAN && !rpt);
	endtask
	task automatic cmd(input logic [7:0] f[$], input logic [7:0] e[$]);
		logic [7:0] b[$];
		logic       ok;
		int         t;
		u_dfsch_host.send(f, ok);
		chk("cmd_taken", 1, ok);
		get(b, t, 1'b0);
		chk("rsp_size", e.size(), b.size());
		foreach (e[i])
			chk("rsp_byte", e[i], b[i]);
	endtask
	// Register bus: address and data offered together, each released when taken
	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr  <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 300);
		tmo(n);
		chk("bresp", er, s_axi_bresp);
	endtask
	task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 300);
		tmo(n);
		chk("rdata", ed, s_axi_rdata);
		chk("rresp", er, s_axi_rresp);
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [7:0] f[$];
		logic [7:0] e[$];
		logic [7:0] b[$];
		int         t[3];
		int         k, hi, n;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axr(REG_CTRL, CTRL_RST, RESP_OK);
		axr(4'hC, 32'h0, RESP_ERR);
		axw(4'hC, 32'h1, RESP_ERR);
		axw(REG_CTRL, 32'h0, RESP_OK);
		repeat (3) @(posedge aclk);
		chk("cmd_ready_off", 0, cmd_ready);
		axw(REG_CTRL, 32'h1, RESP_OK);
		u_dfsch_host.slow = 1'b1;
		cmd('{CMD_CURPOS, LEN_CURPOS, 8'h0F, 8'h01}, '{8'h4B, LEN_NONE});
		chk("cursor", 5'h1F, {cursor_row, cursor_col});
		for (logic [7:0] l = 0; l < 2; l++) begin
			f = '{CMD_LINE1 + l, LEN_LINE};
			e = '{8'h4A, LEN_RD_RSP, 8'h80 + 8'h40 * l, SPACE_CODE, SPACE_CODE};
			for (logic [7:0] j = 0; j < 16; j++) begin
				f.push_back(8'h41 + j + 8'h10 * l);
				if (j < 6)
					e.push_back(8'h41 + j + 8'h10 * l);
			end
			cmd(f, '{f[0] | RSP_FLAG, LEN_NONE});
			cmd('{CMD_MEMRD, LEN_ONE, e[2]}, e);
		end
		disp_rd_addr <= 8'hC2;
		repeat (2) @(posedge aclk);
		chk("disp_rd", 8'h51, disp_rd_data);
		cmd('{CMD_CLEAR, LEN_NONE}, '{8'h46, LEN_NONE});
		chk("cursor", 5'h00, {cursor_row, cursor_col});
		e = '{8'h4A, LEN_RD_RSP, 8'hC2};
		repeat (8) e.push_back(SPACE_CODE);
		cmd('{CMD_MEMRD, LEN_ONE, 8'hC2}, e);
		f = '{CMD_GLYPH, LEN_GLYPH, 8'h07, 8'h3F, 8'h21, 8'h12, 8'h0C, 8'h00, 8'h01, 8'h20, 8'h3F};
		cmd(f, '{8'h49, LEN_NONE});
		e = f;
		e[0] = 8'h4A;
		e[2] = 8'h78;
		cmd('{CMD_MEMRD, LEN_ONE, 8'h78}, e);
		f[2] = 8'h08;
		cmd(f, '{8'hC9, LEN_NONE});
		f[2] = 8'h07;
		f[10] = 8'h40;
		cmd(f, '{8'hC9, LEN_NONE});
		cmd('{CMD_MEMRD, LEN_ONE, 8'h78}, e);
		cmd('{CMD_CURPOS, LEN_CURPOS, 8'h10, 8'h00}, '{8'hCB, LEN_NONE});
		cmd('{CMD_CURPOS, LEN_CURPOS, 8'h00, 8'h02}, '{8'hCB, LEN_NONE});
		cmd('{8'h3F, LEN_NONE}, '{8'hFF, LEN_NONE});
		chk("cursor", 5'h00, {cursor_row, cursor_col});
		for (logic [7:0] s = 0; s < 4; s++) begin
			cmd('{CMD_CURSTY, LEN_ONE, s}, '{8'h4C, LEN_NONE});
			chk("style", s, cursor_style);
		end
		u_dfsch_host.slow = 1'b0;
		cmd('{CMD_FANPWR, LEN_FANPWR, 8'h00, 8'h32, FAN_FULL, 8'h07}, '{8'h51, LEN_NONE});
		chk("fan_level", 32'h0764_3200, fan_level);
		cmd('{CMD_FANPWR, LEN_FANPWR, 8'h00, 8'h00, 8'h65, 8'h00}, '{8'hD1, LEN_NONE});
		axr(REG_FAN, 32'h0764_3200, RESP_OK);
		cmd('{CMD_FANRPT, LEN_ONE, 8'h03}, '{8'h50, LEN_NONE});
		get(b, t[0], 1'b1);
		for (int i = 0; i < 3; i++) begin
			get(b, t[i], 1'b1);
			k = int'(b[2][1:0]);
			if (i == 0)
				hi = k;
			chk("rpt_hdr", {RPT_FAN, LEN_FAN_RSP}, {b[0], b[1]});
			chk("rpt_tach", fan_tach[16 * k +: 16], {b[3], b[4]});
		end
		chk("rpt_period", 4 * SLOT, t[2] - t[0]);
		chk("rpt_stagger", SLOT, (hi == 0) ? t[1] - t[0] : t[2] - t[1]);
		n = 0;
		repeat (4 * SLOT) begin
			@(posedge aclk);
			if (fan_level[7:0] === FAN_FULL)
				n++;
		end
		chk("fan0_forced", SLOT, n);
		cmd('{CMD_FANRPT, LEN_ONE, 8'h00}, '{8'h50, LEN_NONE});
		cmd('{CMD_FANRPT, LEN_ONE, 8'h10}, '{8'hD0, LEN_NONE});
		for (int i = 0; i < 16; i++) begin
			ow_wr_en   <= 1'b1;
			ow_wr_addr <= 8'(40 + i);
			ow_wr_data <= (i == 0) ? FAM_A : (i == 8) ? 8'h33 : 8'(i);
			@(posedge aclk);
		end
		ow_wr_en <= 1'b0;
		@(posedge aclk);
		e = '{8'h52, LEN_RD_RSP, 8'h05, FAM_A};
		for (int i = 1; i < 8; i++)
			e.push_back(8'(i));
		cmd('{CMD_OWINFO, LEN_ONE, 8'h05}, e);
		chk("eligible", 2'b01, temp_eligible[6:5]);
		cmd('{CMD_OWINFO, LEN_ONE, 8'h20}, '{8'hD2, LEN_NONE});
		cmd('{CMD_STORE, LEN_NONE}, '{8'h44, LEN_NONE});
		chk("boot_save", 1, saves);
		end_sim();
	end
endmodule
`default_nettype wire
